// ==== src/motion_regs_defs.svh ====
// Register offsets, field positions, reset values for the motion control block
// Assumes inclusion by the top module only
`ifndef MOTION_REGS_DEFS_SVH
`define MOTION_REGS_DEFS_SVH
`define OFS_MOTION_DETECT_CONTROL 8'h27
`define OFS_SAMPLE_BUFFER_CONTROL 8'h28
`define OFS_SAMPLE_BUFFER_COUNT 8'h29
`define RST_MOTION_DETECT_CONTROL 8'h00
`define RST_SAMPLE_BUFFER_CONTROL 8'h00
`define RST_SAMPLE_BUFFER_COUNT 8'h80
`define BIT_MOTION_ON 0
`define BIT_MOTION_REL 1
`define BIT_STILL_ON 2
`define BIT_STILL_REL 3
`define BIT_SEQ_LO 4
`define BIT_SEQ_HI 5
`define BIT_BUF_TEMP 2
`define BIT_BUF_HIGH 3
`endif

// ==== src/motion_regs_pkg.sv ====
// Types shared by the motion detector control block
// Assumes the defs header is on the include path
package motion_regs_pkg;
    typedef enum logic [1:0] {
        buf_off = 2'b00,
        buf_oldest = 2'b01,
        buf_stream = 2'b10,
        buf_triggered = 2'b11
    } buffer_mode_t;

    // Host register access strobe with address and data
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // One acceleration sample, three signed 12-bit axes
    typedef struct packed {
        logic valid;
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } accel_sample_t;

    // Buffer configuration as decoded from the registers
    typedef struct packed {
        buffer_mode_t mode;
        logic store_temp;
        logic [8:0] count;
    } buffer_cfg_t;
endpackage

// ==== src/motion_fifo_control_regs.sv ====
// Motion detector and sample buffer control registers with the detectors
// Assumes the serial register port is decoded upstream into reg_req strobes
// on ref_clk, and that samples arrive on ref_clk with a one-cycle valid.
// Thresholds and the dwell count are levels held steady by their owner.
// The status register itself lives elsewhere; only its read strobe at
// 0x0b is decoded here to clear the sticky event flags.
//
// Operation
// - Sequencing X0: both detectors run independently, host read clears
// - Sequencing 01: detectors alternate one at a time, host read clears
// - Sequencing 11: detectors alternate, events acknowledged internally
// - Linked or loop only when both detector enables set, else default
// - Control bit 3 picks referenced or absolute stillness compare
// - Control bit 1 picks referenced or absolute motion compare
// - Control bit 2 enables stillness detection
// - Control bit 0 enables motion detection
// - Buffer control bit 3 is the count's ninth bit, range 0 to 511
// - Buffer control bit 2 stores temperature with acceleration
// - Buffer mode bits select off, oldest saved, stream, triggered
// - Nine-bit count sets how many samples the buffer stores
// - Sample count register resets to 0x80
// - Motion compares each axis magnitude against 11-bit limit
// - Stillness needs dwell count consecutive quiet samples, zero as one
`include "motion_regs_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module motion_fifo_control_regs
    import motion_regs_pkg::*;
(
    input wire logic ref_clk, // 50 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire reg_req_t reg_req, // Register access strobes
    input wire accel_sample_t sample, // New acceleration sample
    input wire logic [10:0] motion_level_limit, // Motion threshold
    input wire logic [10:0] stillness_level_limit, // Stillness threshold
    input wire logic [15:0] stillness_dwell_count, // Quiet samples needed
    output logic [7:0] reg_rdata, // Read data, valid after rd
    output buffer_cfg_t buffer_cfg, // Decoded buffer setup
    output logic motion_event, // Sticky motion status
    output logic stillness_event, // Sticky stillness status
    output logic motion_armed, // Motion detector running
    output logic stillness_armed // Stillness detector running
);
    logic [7:0] motion_detect_control;
    logic [7:0] sample_buffer_control;
    logic [7:0] sample_buffer_count;
    logic [11:0] ref_x, ref_y, ref_z;
    logic [15:0] quiet_run;
    logic seq_phase; // 0 watches motion, 1 watches stillness
    logic [2:0] next_arm;

    // Register decode. Strobes are one cycle wide, so each decode term
    // is true for exactly one edge per host access; no edge detection is
    // needed and back to back accesses need no spacing.
    // The status read is decoded here only to clear the event flags.
    wire wr_ctl = reg_req.wr &&
        reg_req.addr == `OFS_MOTION_DETECT_CONTROL;
    wire wr_bctl = reg_req.wr &&
        reg_req.addr == `OFS_SAMPLE_BUFFER_CONTROL;
    wire wr_cnt = reg_req.wr && reg_req.addr == `OFS_SAMPLE_BUFFER_COUNT;
    wire status_rd = reg_req.rd && reg_req.addr == 8'h0b;
    wire motion_on = motion_detect_control[`BIT_MOTION_ON];
    wire still_on = motion_detect_control[`BIT_STILL_ON];
    wire motion_rel = motion_detect_control[`BIT_MOTION_REL];
    wire still_rel = motion_detect_control[`BIT_STILL_REL];
    wire seq_lo = motion_detect_control[`BIT_SEQ_LO];
    wire seq_hi = motion_detect_control[`BIT_SEQ_HI];
    // Sequencing needs both detectors on, otherwise independent
    wire sequenced = seq_lo && motion_on && still_on;
    wire loop_mode = sequenced && seq_hi;
    wire run_motion = sequenced ? !seq_phase : motion_on;
    wire run_still = sequenced ? seq_phase : still_on;

    // Magnitude of each axis, raw or relative to the armed reference.
    // The most negative code folds onto itself; it still reads as large,
    // which is the safe direction for a motion detector.
    function automatic logic [11:0] mag(input logic [11:0] s,
                                        input logic [11:0] r,
                                        input logic rel);
        logic [11:0] d;
        d = rel ? s - r : s;
        mag = d[11] ? 12'(-d) : d;
    endfunction

    // Each detector has its own compare method, so both sets of
    // magnitudes are formed; they share only the captured reference.
    // The 11-bit limits are zero extended to the magnitude width.
    wire [11:0] mx_a = mag(sample.x, ref_x, motion_rel);
    wire [11:0] my_a = mag(sample.y, ref_y, motion_rel);
    wire [11:0] mz_a = mag(sample.z, ref_z, motion_rel);
    wire [11:0] mx_s = mag(sample.x, ref_x, still_rel);
    wire [11:0] my_s = mag(sample.y, ref_y, still_rel);
    wire [11:0] mz_s = mag(sample.z, ref_z, still_rel);
    wire [11:0] act_lim = {1'b0, motion_level_limit};
    wire [11:0] ina_lim = {1'b0, stillness_level_limit};
    // Any axis above the limit counts as motion
    wire over = mx_a > act_lim || my_a > act_lim || mz_a > act_lim;
    wire under = mx_s < ina_lim && my_s < ina_lim && mz_s < ina_lim;
    // Zero dwell behaves as one sample
    wire [15:0] dwell = (stillness_dwell_count == 16'h0000) ?
        16'h0001 : stillness_dwell_count;
    wire act_hit = sample.valid && run_motion && over;
    wire ina_hit = sample.valid && run_still && under &&
        quiet_run + 16'h0001 >= dwell;
    // Reference is recaptured on the sample that arms a detector
    wire arm_edge = sequenced && (act_hit || ina_hit);

    // Host writable registers. Every bit is stored as written, unused
    // ones included, so software reading back a setup sees what it wrote.
    // Writes to offsets not decoded here simply fall through.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            motion_detect_control <= `RST_MOTION_DETECT_CONTROL;
            sample_buffer_control <= `RST_SAMPLE_BUFFER_CONTROL;
            sample_buffer_count <= `RST_SAMPLE_BUFFER_COUNT;
        end else begin
            if (wr_ctl) begin
                motion_detect_control <= reg_req.wdata;
            end
            if (wr_bctl) begin
                sample_buffer_control <= reg_req.wdata;
            end
            if (wr_cnt) begin
                sample_buffer_count <= reg_req.wdata;
            end
        end
    end

    // Consecutive quiet sample counter, saturating.
    // Any control write restarts the run, since a changed threshold mode
    // makes the samples counted so far meaningless.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quiet_run <= 16'h0000;
        end else if (!run_still || wr_ctl || ina_hit) begin
            quiet_run <= 16'h0000;
        end else if (sample.valid) begin
            quiet_run <= under ? ((quiet_run == 16'hffff) ? quiet_run :
                quiet_run + 16'h0001) : 16'h0000;
        end
    end

    // Alternation between detectors and reference capture.
    // A control write restarts sequencing on the motion detector, so the
    // host always knows which detector runs after it changes the mode.
    // The reference follows the sample bus on a control write; a user
    // must arm a referenced detector while the part is at rest.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seq_phase <= 1'b0;
            ref_x <= 12'h000;
            ref_y <= 12'h000;
            ref_z <= 12'h000;
        end else begin
            if (!sequenced || wr_ctl) begin
                seq_phase <= 1'b0;
            end else if (act_hit || ina_hit) begin
                seq_phase <= !seq_phase;
            end
            if (wr_ctl || arm_edge) begin
                ref_x <= sample.x;
                ref_y <= sample.y;
                ref_z <= sample.z;
            end
        end
    end

    // Sticky events: a new hit beats a clearing read in the same cycle.
    // Loop mode acknowledges internally, so flags pulse for one sample.
    // Entering loop mode drops any flag left pending from another mode,
    // because nothing in loop mode would ever clear it.
    assign next_arm = {loop_mode, act_hit, ina_hit};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            motion_event <= 1'b0;
            stillness_event <= 1'b0;
        end else if (next_arm[2]) begin
            motion_event <= next_arm[1];
            stillness_event <= next_arm[0];
        end else begin
            motion_event <= next_arm[1] | (motion_event & !status_rd);
            stillness_event <= next_arm[0] |
                (stillness_event & !status_rd);
        end
    end

    // Read mux and registered outputs. Read data follows the address of
    // the previous cycle whatever the strobes say, which keeps the mux
    // free of strobe timing; unmapped offsets read as zero.
    // Buffer setup and armed flags trail their sources by one cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            buffer_cfg <= '0;
            motion_armed <= 1'b0;
            stillness_armed <= 1'b0;
        end else begin
            unique case (reg_req.addr)
                `OFS_MOTION_DETECT_CONTROL: reg_rdata <= motion_detect_control;
                `OFS_SAMPLE_BUFFER_CONTROL: reg_rdata <= sample_buffer_control;
                `OFS_SAMPLE_BUFFER_COUNT: reg_rdata <= sample_buffer_count;
                default: reg_rdata <= 8'h00;
            endcase
            buffer_cfg.mode <= buffer_mode_t'(sample_buffer_control[1:0]);
            buffer_cfg.store_temp <=
                sample_buffer_control[`BIT_BUF_TEMP];
            buffer_cfg.count <= {sample_buffer_control[`BIT_BUF_HIGH],
                sample_buffer_count};
            motion_armed <= run_motion;
            stillness_armed <= run_still;
        end
    end
endmodule
`default_nettype wire

// ==== tb/motion_regs_props.sv ====
// Port checker for the motion control block
// Assumes binding onto the block; mirrors the control register
`timescale 1ns/100ps
`default_nettype none
module motion_regs_props
    import motion_regs_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire reg_req_t reg_req, // Strobes
    input wire buffer_cfg_t buffer_cfg, // Buffer setup
    input wire logic motion_event, // Motion flag
    input wire logic motion_armed, // Motion running
    input wire logic stillness_armed // Stillness running
);
    logic [7:0] ctl;
    wire w28 = reg_req.wr && reg_req.addr == 8'h28;
    wire w29 = reg_req.wr && reg_req.addr == 8'h29;
    wire both = ctl[0] && ctl[2];
    wire lp = both && ctl[5:4] == 2'b11;
    wire clr = reg_req.rd && reg_req.addr == 8'h0b;
    // Mirror, so modes are known without peeking inside
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) ctl <= 8'h00;
        else if (reg_req.wr && reg_req.addr == 8'h27) ctl <= reg_req.wdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_cnt;
        w29 |=> ##1 buffer_cfg.count[7:0] == $past(reg_req.wdata, 2);
    endproperty
    a_cnt: assert property (p_cnt) else $error("count low wrong");
    property p_hi;
        w28 |=> ##1 buffer_cfg.count[8] == $past(reg_req.wdata[3], 2);
    endproperty
    a_hi: assert property (p_hi) else $error("count high wrong");
    property p_mode;
        w28 |=> ##1 buffer_cfg.mode == $past(reg_req.wdata[1:0], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_rst;
        $past(rst) |=> buffer_cfg.count == 9'h080;
    endproperty
    a_rst: assert property (p_rst) else $error("count reset wrong");
    property p_mon;
        $stable(ctl) && !ctl[0] |-> !motion_armed;
    endproperty
    a_mon: assert property (p_mon) else $error("motion armed");
    property p_one;
        $stable(ctl) && both && ctl[4] |->
            !(motion_armed && stillness_armed);
    endproperty
    a_one: assert property (p_one) else $error("both armed");
    property p_loop;
        $stable(ctl) && lp && motion_event |=> !motion_event;
    endproperty
    a_loop: assert property (p_loop) else $error("loop flag held");
    property p_stk;
        $stable(ctl) && !lp && !reg_req.wr && !clr && motion_event |=>
            motion_event;
    endproperty
    a_stk: assert property (p_stk) else $error("flag lost");
endmodule
bind motion_fifo_control_regs motion_regs_props i_motion_regs_props (
    .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .buffer_cfg(buffer_cfg),
    .motion_event(motion_event), .motion_armed(motion_armed),
    .stillness_armed(stillness_armed));
`default_nettype wire

// ==== tb/host_port_model.sv ====
// Host model issuing one-cycle register strobes
// Assumes read data one cycle after the address is taken
`timescale 1ns/100ps
`default_nettype none
module host_port_model
    import motion_regs_pkg::*;
(
    input wire logic ref_clk, // Clock
    output var reg_req_t req, // Strobes
    input wire logic [7:0] rdata // Read data
);
    initial req = '0;
    // Idle fields flip so a stale address is never trusted
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        @(negedge ref_clk);
        req <= '{w, !w, a, d};
        @(negedge ref_clk);
        q = rdata;
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_motion_fifo_control_regs.sv ====
// Testbench for the motion control block
// Assumes the host model and checker compile first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", n, e, v); end end
module tb_motion_fifo_control_regs
    import motion_regs_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t rq;
    accel_sample_t smp = '0;
    logic [7:0] rdat, q;
    buffer_cfg_t cfg;
    logic mev, sev, marm, sarm;
    int n_fail = 0;
    int cmp_count = 0;
    always #10 ref_clk = ~ref_clk;
    motion_fifo_control_regs i_motion_fifo_control_regs (.ref_clk(ref_clk),
        .rst(rst), .reg_req(rq), .sample(smp), .motion_level_limit(11'h064),
        .stillness_level_limit(11'h064), .stillness_dwell_count(16'h0003),
        .reg_rdata(rdat), .buffer_cfg(cfg), .motion_event(mev),
        .stillness_event(sev), .motion_armed(marm), .stillness_armed(sarm));
    host_port_model i_host_port_model (.ref_clk(ref_clk), .req(rq),
        .rdata(rdat));
    // Register access and sample helpers
    task automatic wr(input logic [7:0] a, d);
        i_host_port_model.xfer(1'b1, a, d, q);
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, e);
        i_host_port_model.xfer(1'b0, a, 8'h00, q);
        `CHK("rdata", e, q)
    endtask
    task automatic hit(input logic [11:0] x);
        @(negedge ref_clk);
        smp <= '{1'b1, x, 12'h000, 12'h000};
        @(negedge ref_clk);
        smp.valid <= 1'b0;
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog well past the hundred or so cycles the tests need
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (3) @(negedge ref_clk);
        rst <= 1'b0;
        rd(8'h27, 8'h00);
        rd(8'h29, 8'h80);
        rd(8'h30, 8'h00);
        wr(8'h27, 8'hc0);
        rd(8'h27, 8'hc0);
        wr(8'h28, 8'hf0);
        rd(8'h28, 8'hf0);
        for (int m = 0; m < 4; m++) begin
            wr(8'h28, 8'h0c | 8'(m));
            wr(8'h29, 8'(m * 85));
            `CHK("mode", 2'(m), cfg.mode)
            `CHK("count", {1'b1, 8'(m * 85)}, cfg.count)
            `CHK("temp", 1'b1, cfg.store_temp)
        end
        wr(8'h27, 8'h01);
        hit(12'hf9c);
        `CHK("quiet", 1'b0, mev)
        hit(12'hf9b);
        `CHK("motion", 1'b1, mev)
        rd(8'h0b, 8'h00);
        `CHK("cleared", 1'b0, mev)
        wr(8'h27, 8'h04);
        hit(12'h000);
        hit(12'h000);
        `CHK("early", 1'b0, sev)
        hit(12'h000);
        `CHK("still", 1'b1, sev)
        wr(8'h27, 8'h15);
        `CHK("link arm", 2'b10, {marm, sarm})
        hit(12'h7ff);
        @(negedge ref_clk);
        `CHK("link flip", 3'b101, {mev, marm, sarm})
        wr(8'h27, 8'h35);
        hit(12'h7ff);
        `CHK("loop pulse", 1'b1, mev)
        @(negedge ref_clk);
        `CHK("loop ack", 1'b0, mev)
        wr(8'h27, 8'h31);
        hit(12'h7ff);
        @(negedge ref_clk);
        `CHK("fallback", 1'b1, mev)
        rd(8'h0b, 8'h00);
        wr(8'h27, 8'h03);
        hit(12'h7ff);
        `CHK("rel rest", 1'b0, mev)
        hit(12'h79a);
        `CHK("rel move", 1'b1, mev)
        wr(8'h27, 8'h0c);
        hit(12'h79a);
        hit(12'h79a);
        hit(12'h79a);
        `CHK("rel still", 1'b1, sev)
        close_out();
    end
endmodule
`default_nettype wire
